// File: serdes_cfg_params.svh
// Purpose: Constants for the low-speed SERDES configuration register bank
// Assumes: Included by the two design modules
// Notes: Offsets are management register addresses within the vendor device address
`ifndef SERDES_CFG_PARAMS_SVH
`define SERDES_CFG_PARAMS_SVH

`define LS_DEV_ADDR 5'h1E
`define LS_CTRL_ONE_ADDR 16'h0006
`define LS_CTRL_TWO_ADDR 16'h0007
`define LS_CTRL_ONE_RESET 16'h0015
`define LS_CTRL_TWO_RESET 16'hDC04
`define LS_MPY_MSB 3
`define LS_MPY_LSB 0
`define LS_MPY_RESET 4'b0101
`define LS_AMP_MSB 14
`define LS_AMP_LSB 12
`define LS_AMP_RESET 3'b101
`define LS_SIGNAL_LOSS_DETECT_EN_BIT 11
`define LS_TX_EN_BIT 10
`define LS_TRANSMIT_LANE_RATE_MSB 9
`define LS_TRANSMIT_LANE_RATE_LSB 8
`define LS_DE_MSB 7
`define LS_DE_LSB 4
`define LS_RX_EN_BIT 2
`define LS_RECEIVE_LANE_RATE_MSB 1
`define LS_RECEIVE_LANE_RATE_LSB 0
`define LS_RATE_RESERVED 2'b11
`define LS_READ_NONE 16'h0000

`endif

// File: serdes_cfg_pkg.sv
// Purpose: Types for the low-speed SERDES configuration register bank
// Assumes: serdes_cfg_params.svh holds the numbers
// Notes: Lane mode encodes how many low-speed lanes are in use
package serdes_cfg_pkg;

  typedef enum logic [1:0]
  {
    lane_mode_four = 2'b00,
    lane_mode_two = 2'b01,
    lane_mode_one = 2'b10,
    lane_mode_kx = 2'b11
  } lane_mode_type;

  typedef enum logic [1:0]
  {
    rate_full = 2'b00,
    rate_half = 2'b01,
    rate_quarter = 2'b10,
    rate_reserved = 2'b11
  } lane_rate_type;

  typedef struct packed
  {
    logic [2:0] ls_output_amplitude;
    logic ls_signal_loss_detect_en;
    logic [3:0] ls_transmit_lane_en;
    logic [1:0] ls_transmit_lane_rate;
    logic [3:0] ls_output_deemph;
    logic [3:0] ls_receive_lane_en;
    logic [1:0] ls_receive_lane_rate;
    logic [3:0] ls_pll_multiplier;
    logic [7:0] ls_pll_factor_x2;
    logic ls_pll_code_valid;
  } serdes_ctrl_type;

  typedef struct packed
  {
    logic wr_en;
    logic rd_en;
    logic [4:0] dev_addr;
    logic [15:0] reg_addr;
    logic [15:0] wr_data;
  } mgmt_req_type;

endpackage : serdes_cfg_pkg

// File: lane_enable_gate.sv
// Purpose: Works out which low-speed lanes of one direction run
// Assumes: Power-down inputs are already synchronised
// Notes: Purely combinational
`timescale 1ns/100ps
`default_nettype none
`include "serdes_cfg_params.svh"

module lane_enable_gate
  import serdes_cfg_pkg::*;
(
  // Controls
  input wire logic lane_en_bit,
  input wire logic powerdown_n,
  input wire logic global_powerdown,
  input wire lane_mode_type lane_mode,
  // Result
  output logic [3:0] lane_on
);

  wire all_off = !powerdown_n || global_powerdown;
  wire upper_off = (lane_mode != lane_mode_four);
  wire lane1_off = (lane_mode == lane_mode_one) || (lane_mode == lane_mode_kx);
  wire base_on = lane_en_bit && !all_off;

  assign lane_on = {base_on && !upper_off, base_on && !upper_off, base_on && !lane1_off, base_on};

endmodule : lane_enable_gate
`default_nettype wire

// File: lowspeed_serdes_config_regs.sv
// Purpose: Low-speed SERDES control registers one and two with lane enable logic
// Assumes: Management frames already decoded into single-cycle requests
// Notes: Read data answers one cycle after a read request
// Functional notes
// - Multiplier field bits 3:0, reset 0101
// - Multiplier codes decode; reserved codes flagged
// - Register 1E.0007, 16 bits, reset 0xDC04
// - Bits 14:12 amplitude, reset 101
// - Bit 11 loss-of-signal detect enable
// - Bit 10 transmit lane enable
// - Power-down pin or global bit forces off
// - Transmit lanes dropped by lane mode
// - Receive lanes dropped by lane mode
// - Bits 9:8 transmit rate; 11 reserved
// - Bits 7:4 de-emphasis, sixteen steps
// - Bit 2 receive lane enable
// - Bits 1:0 receive rate; 11 reserved
`timescale 1ns/100ps
`default_nettype none
`include "serdes_cfg_params.svh"

module lowspeed_serdes_config_regs
  import serdes_cfg_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Management access
  input wire mgmt_req_type mgmt_req,
  output logic [15:0] rd_data,
  output logic rd_valid,
  // Pins and global controls
  input wire logic channel_powerdown_n,
  input wire logic global_powerdown,
  input wire lane_mode_type lane_mode,
  // SERDES controls
  output serdes_ctrl_type serdes_ctrl,
  output logic rate_code_reserved
);

  // Twice the multiplier factor, so 12.5x stays an integer
  function automatic logic [7:0] mpy_decode(input logic [3:0] code);
    logic [7:0] res;
    res = 8'h00;
    case (code)
      4'h0: res = 8'h08;
      4'h1: res = 8'h0A;
      4'h2: res = 8'h0C;
      4'h4: res = 8'h10;
      4'h5: res = 8'h14;
      4'h6: res = 8'h18;
      4'h7: res = 8'h19;
      4'h8: res = 8'h1E;
      4'h9: res = 8'h28;
      4'hA: res = 8'h32;
      4'hD: res = 8'h64;
      4'hE: res = 8'h82;
      default: res = 8'h00;
    endcase
    return res;
  endfunction : mpy_decode

  // A rate field of 11 has no defined lane rate
  function automatic logic rate_is_reserved(input logic [1:0] rate);
    return rate == `LS_RATE_RESERVED;
  endfunction : rate_is_reserved

  logic [15:0] ctrl_one_ff;
  logic [15:0] ctrl_two_ff;
  logic [15:0] rd_data_ff;
  logic rd_valid_ff;
  logic pd_s1_ff;
  logic pd_s2_ff;
  logic pd_s3_ff;
  logic pd_stable_ff;
  serdes_ctrl_type ctrl_ff;
  logic rate_rsv_ff;

  wire dev_hit = (mgmt_req.dev_addr == `LS_DEV_ADDR);
  wire hit_one = dev_hit && (mgmt_req.reg_addr == `LS_CTRL_ONE_ADDR);
  wire hit_two = dev_hit && (mgmt_req.reg_addr == `LS_CTRL_TWO_ADDR);
  wire wr_one = mgmt_req.wr_en && hit_one;
  wire wr_two = mgmt_req.wr_en && hit_two;
  wire [15:0] nxt_rd_data = hit_one ? ctrl_one_ff : (hit_two ? ctrl_two_ff : `LS_READ_NONE);

  // Pin filter: accept a change once stages two and three agree
  // Filter resets to powered down, so lanes wake only once the pin is seen high
  wire nxt_pd_stable = (pd_s2_ff == pd_s3_ff) ? pd_s3_ff : pd_stable_ff;

  wire [3:0] pll_code = ctrl_one_ff[`LS_MPY_MSB:`LS_MPY_LSB];
  wire [7:0] pll_x2 = mpy_decode(pll_code);
  wire [1:0] tx_rate = ctrl_two_ff[`LS_TRANSMIT_LANE_RATE_MSB:`LS_TRANSMIT_LANE_RATE_LSB];
  wire [1:0] rx_rate = ctrl_two_ff[`LS_RECEIVE_LANE_RATE_MSB:`LS_RECEIVE_LANE_RATE_LSB];
  wire nxt_rate_rsv = rate_is_reserved(tx_rate) || rate_is_reserved(rx_rate);
  logic [3:0] tx_lanes;
  logic [3:0] rx_lanes;

  lane_enable_gate tx_gate
  (
    .lane_en_bit(ctrl_two_ff[`LS_TX_EN_BIT]),
    .powerdown_n(pd_stable_ff),
    .global_powerdown(global_powerdown),
    .lane_mode(lane_mode),
    .lane_on(tx_lanes)
  );

  lane_enable_gate rx_gate
  (
    .lane_en_bit(ctrl_two_ff[`LS_RX_EN_BIT]),
    .powerdown_n(pd_stable_ff),
    .global_powerdown(global_powerdown),
    .lane_mode(lane_mode),
    .lane_on(rx_lanes)
  );

  wire [2:0] amp_field = ctrl_two_ff[`LS_AMP_MSB:`LS_AMP_LSB];
  wire los_bit = ctrl_two_ff[`LS_SIGNAL_LOSS_DETECT_EN_BIT];
  wire [3:0] de_field = ctrl_two_ff[`LS_DE_MSB:`LS_DE_LSB];

  serdes_ctrl_type nxt_ctrl;
  assign nxt_ctrl.ls_output_amplitude = amp_field;
  assign nxt_ctrl.ls_signal_loss_detect_en = los_bit;
  assign nxt_ctrl.ls_transmit_lane_en = tx_lanes;
  assign nxt_ctrl.ls_transmit_lane_rate = tx_rate;
  assign nxt_ctrl.ls_output_deemph = de_field;
  assign nxt_ctrl.ls_receive_lane_en = rx_lanes;
  assign nxt_ctrl.ls_receive_lane_rate = rx_rate;
  assign nxt_ctrl.ls_pll_multiplier = pll_code;
  assign nxt_ctrl.ls_pll_factor_x2 = pll_x2;
  assign nxt_ctrl.ls_pll_code_valid = (pll_x2 != 8'h00);

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      ctrl_one_ff <= `LS_CTRL_ONE_RESET;
    end
    else if (wr_one)
    begin
      ctrl_one_ff <= mgmt_req.wr_data;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      ctrl_two_ff <= `LS_CTRL_TWO_RESET;
    end
    else if (wr_two)
    begin
      ctrl_two_ff <= mgmt_req.wr_data;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      rd_valid_ff <= 1'b0;
    end
    else
    begin
      rd_valid_ff <= mgmt_req.rd_en;
    end
  end

  // Read data holds its value until the next read
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      rd_data_ff <= 16'h0000;
    end
    else if (mgmt_req.rd_en)
    begin
      rd_data_ff <= nxt_rd_data;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      pd_s1_ff <= 1'b0;
      pd_s2_ff <= 1'b0;
      pd_s3_ff <= 1'b0;
      pd_stable_ff <= 1'b0;
    end
    else
    begin
      pd_s1_ff <= channel_powerdown_n;
      pd_s2_ff <= pd_s1_ff;
      pd_s3_ff <= pd_s2_ff;
      pd_stable_ff <= nxt_pd_stable;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      ctrl_ff <= '0;
    end
    else
    begin
      ctrl_ff <= nxt_ctrl;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      rate_rsv_ff <= 1'b0;
    end
    else
    begin
      rate_rsv_ff <= nxt_rate_rsv;
    end
  end

  assign rd_data = rd_data_ff;
  assign rd_valid = rd_valid_ff;
  assign serdes_ctrl = ctrl_ff;
  assign rate_code_reserved = rate_rsv_ff;

endmodule : lowspeed_serdes_config_regs
`default_nettype wire

// File: serdes_cfg_properties.sv
// Purpose: Checks on the SERDES config bank
// Assumes: Bound to the bank top module
// Notes: Controls lag the register one cycle
`timescale 1ns/100ps
`default_nettype none
module serdes_cfg_properties
  import serdes_cfg_pkg::*;
(
  // Clock
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Bus
  input wire mgmt_req_type mgmt_req,
  input wire logic [15:0] rd_data,
  input wire logic rd_valid,
  // Lanes
  input wire logic channel_powerdown_n,
  input wire logic global_powerdown,
  input wire lane_mode_type lane_mode,
  input wire serdes_ctrl_type serdes_ctrl,
  input wire logic rate_code_reserved
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  wire logic [15:0] d = mgmt_req.wr_data;
  wire logic wr7 = mgmt_req.wr_en && mgmt_req.dev_addr == 5'h1E && mgmt_req.reg_addr == 16'h0007;
  wire logic [3:0] txl = serdes_ctrl.ls_transmit_lane_en;
  wire logic [3:0] rxl = serdes_ctrl.ls_receive_lane_en;
  wire logic off = txl == 4'h0 && rxl == 4'h0;
  wire logic [11:0] fw = {d[14:11], d[9:4], d[1:0]};
  wire logic [11:0] fq = {serdes_ctrl.ls_output_amplitude, serdes_ctrl.ls_signal_loss_detect_en,
    serdes_ctrl.ls_transmit_lane_rate, serdes_ctrl.ls_output_deemph, serdes_ctrl.ls_receive_lane_rate};
  fields_track_a: assert property (wr7 |-> ##2 fq == $past(fw, 2))
    else $error("field mismatch");
  tx_off_a: assert property (wr7 && !d[10] |-> ##2 txl == 4'h0)
    else $error("tx lanes on");
  rx_off_a: assert property (wr7 && !d[2] |-> ##2 rxl == 4'h0)
    else $error("rx lanes on");
  global_off_a: assert property (global_powerdown |=> off)
    else $error("lanes on in power down");
  pin_off_a: assert property (!channel_powerdown_n [*8] |=> off)
    else $error("lanes on with pin low");
  mode_two_a: assert property (lane_mode == lane_mode_two |=> txl[3:2] == 2'b00 && rxl[3:2] == 2'b00)
    else $error("upper lanes on");
  mode_one_a: assert property (lane_mode inside {lane_mode_one, lane_mode_kx} |=> txl[3:1] == 3'h0 && rxl[3:1] == 3'h0)
    else $error("lanes 1 to 3 on");
  unmapped_rd_a: assert property (mgmt_req.rd_en && mgmt_req.dev_addr != 5'h1E |=> rd_valid && rd_data == 16'h0000)
    else $error("unmapped read wrong");
  cover property (wr7 ##2 rate_code_reserved);
  cover property (global_powerdown ##1 off);
  cover property (lane_mode == lane_mode_kx);
endmodule : serdes_cfg_properties
bind lowspeed_serdes_config_regs serdes_cfg_properties chk (.ref_clk(ref_clk), .sys_rst(sys_rst),
  .mgmt_req(mgmt_req), .rd_data(rd_data), .rd_valid(rd_valid), .channel_powerdown_n(channel_powerdown_n),
  .global_powerdown(global_powerdown), .lane_mode(lane_mode), .serdes_ctrl(serdes_ctrl),
  .rate_code_reserved(rate_code_reserved));
`default_nettype wire

// File: testbench.sv
// Purpose: Random and corner tests of the config bank
// Assumes: Reads answer one cycle after the request
// Notes: Lane gating is checked here and by the bound checks
`timescale 1ns/100ps
`default_nettype none
module testbench
  import serdes_cfg_pkg::*;
;
  logic ref_clk = 0;
  logic sys_rst = 1;
  logic pd_n = 1;
  logic gpd = 0;
  logic rv, rsv;
  logic [15:0] rdd, v;
  logic [31:0] s = 32'h0000_842c;
  int error_cnt = 0;
  int check_count = 0;
  int cyc = 0;
  mgmt_req_type req = '0;
  lane_mode_type md = lane_mode_four;
  serdes_ctrl_type c;
  lowspeed_serdes_config_regs dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .mgmt_req(req), .rd_data(rdd),
    .rd_valid(rv), .channel_powerdown_n(pd_n), .global_powerdown(gpd), .lane_mode(md),
    .serdes_ctrl(c), .rate_code_reserved(rsv));
  initial forever #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk)
    if (++cyc == 3000)
    begin
      error_cnt++;
      final_report();
    end
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr
  function automatic logic bad_rate(input logic [15:0] w);
    return w[9:8] == 2'b11 || w[1:0] == 2'b11;
  endfunction : bad_rate
  function automatic logic [7:0] exp_lanes(input int m);
    return m == 0 ? 8'hFF : m == 1 ? 8'h33 : 8'h11;
  endfunction : exp_lanes
  function automatic logic [7:0] mpy_x2(input int k);
    logic [7:0] t [16] = '{8'h08, 8'h0A, 8'h0C, 8'h00, 8'h10, 8'h14, 8'h18, 8'h19,
      8'h1E, 8'h28, 8'h32, 8'h00, 8'h00, 8'h64, 8'h82, 8'h00};
    return t[k];
  endfunction : mpy_x2
  task automatic final_report();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : final_report
  task automatic chk(input logic [15:0] e, input logic [15:0] g, input string n);
    check_count++;
    if (g !== e)
    begin
      error_cnt++;
      $display("ERROR %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task automatic acc(input logic [1:0] k, input logic [4:0] a, input logic [15:0] r, input logic [15:0] w);
    @(posedge ref_clk) req <= {k, a, r, w};
    @(posedge ref_clk) req <= '0;
    #1;
  endtask : acc
  task automatic rd(input logic [4:0] a, input logic [15:0] e);
    acc(2'b01, a, 16'h0007, 16'h0000);
    chk(e, rdd, "rd_data");
    chk(16'h0001, {15'h0000, rv}, "rd_valid");
  endtask : rd
  initial
  begin
    repeat (20) @(posedge ref_clk);
    sys_rst <= 1'b0;
    rd(5'h1E, 16'hDC04);
    chk(16'h0005, {12'h000, c.ls_pll_multiplier}, "mpy");
    for (int i = 0; i < 14; i++)
    begin
      s = lfsr(s);
      v = i == 0 ? 16'hFFF7 : i == 1 ? 16'h8000 : (s[15:0] & 16'h7FF7) | 16'h8000;
      acc(2'b10, 5'h1E, 16'h0007, v);
      rd(5'h1E, v);
      chk({15'h0000, bad_rate(v)}, {15'h0000, rsv}, "rate_flag");
    end
    acc(2'b10, 5'h01, 16'h0007, 16'h0000);
    rd(5'h01, 16'h0000);
    rd(5'h1E, v);
    acc(2'b10, 5'h1E, 16'h0007, 16'hDC04);
    for (int m = 3; m >= 0; m--)
    begin
      @(posedge ref_clk) md <= lane_mode_type'(m);
      repeat (2) @(posedge ref_clk);
      #1;
      chk({8'h00, exp_lanes(m)}, {8'h00, c.ls_transmit_lane_en, c.ls_receive_lane_en}, "lanes");
    end
    @(posedge ref_clk) gpd <= 1'b1;
    @(posedge ref_clk) gpd <= 1'b0;
    pd_n <= 1'b0;
    #1;
    chk(16'h0000, {8'h00, c.ls_transmit_lane_en, c.ls_receive_lane_en}, "gpd_lanes");
    repeat (10) @(posedge ref_clk);
    pd_n <= 1'b1;
    #1;
    chk(16'h0000, {8'h00, c.ls_transmit_lane_en, c.ls_receive_lane_en}, "pin_lanes");
    repeat (6) @(posedge ref_clk);
    #1;
    chk(16'h00FF, {8'h00, c.ls_transmit_lane_en, c.ls_receive_lane_en}, "wake_lanes");
    for (int k = 0; k < 16; k++)
    begin
      acc(2'b10, 5'h1E, 16'h0006, {12'h001, k[3:0]});
      @(posedge ref_clk);
      #1;
      chk({15'h0000, !(k inside {3, 11, 12, 15})}, {15'h0000, c.ls_pll_code_valid}, "mpy_ok");
      chk({8'h00, mpy_x2(k)}, {8'h00, c.ls_pll_factor_x2}, "mpy_factor");
      chk({12'h000, k[3:0]}, {12'h000, c.ls_pll_multiplier}, "mpy_field");
    end
    final_report();
  end
endmodule : testbench
`default_nettype wire
